// ---- hw/srg_regs.vh ----
`ifndef SRG_REGS_VH
`define SRG_REGS_VH

// printed register indices; byte address is four times the index
`define SRG_IDX_CTRL        4'h0
`define SRG_IDX_RATE        4'h2
`define SRG_IDX_STATUS      4'h3
`define SRG_IDX_DATA        4'h5
`define SRG_IDX_IRQ_STS     4'h8
`define SRG_IDX_IRQ_EN      4'h9
`define SRG_IDX_IRQ_CLR     4'hA

// byte addresses on the bus
`define SRG_ADDR_CTRL       8'h00
`define SRG_ADDR_RATE       8'h08
`define SRG_ADDR_STATUS     8'h0C
`define SRG_ADDR_DATA       8'h14
`define SRG_ADDR_IRQ_STS    8'h20
`define SRG_ADDR_IRQ_EN     8'h24
`define SRG_ADDR_IRQ_CLR    8'h28

// control register fields
`define SRG_CTRL_RUN        0
`define SRG_CTRL_RXDMA      1
`define SRG_CTRL_W          2
`define SRG_CTRL_RST        2'h0

// bit rate setting fields
`define SRG_RATE_RST        8'h00
`define SRG_RATE_WMASK      8'h7F
`define SRG_PRE_HI          6
`define SRG_PRE_LO          4
`define SRG_DIV_HI          3
`define SRG_DIV_LO          0

// serial status fields
`define SRG_STS_RXFULL      7

// divider select limits
`define SRG_DIV_MAX_CODE    4'h8

// interrupt event bits
`define SRG_EV_XFER         0
`define SRG_EV_RXCLR        1
`define SRG_EV_W            2
`define SRG_EV_RST          2'h0

// bus encodings
`define SRG_HTRANS_NONSEQ   2'h2
`define SRG_HRESP_OKAY      1'h0
`define SRG_WORD_SHIFT      2

`endif

// ---- hw/srg_rate_gen.v ----
`timescale 1ns/100ps
`include "srg_regs.vh"

// prescaler and power-of-two divider that pace the serial clock
module srg_rate_gen
(
    // clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // settings
    input  wire       i_run,
    input  wire [2:0] i_pre_sel,
    input  wire [3:0] i_div_sel,
    // outputs
    output wire       o_pre_tick,
    output wire       o_edge,
    output wire       o_sclk
);

    reg  [2:0] pre_cnt_ff;
    reg  [8:0] div_cnt_ff;
    reg        sclk_ff;
    reg  [2:0] nxt_pre_cnt;
    reg  [8:0] nxt_div_cnt;
    reg        nxt_sclk;
    wire [3:0] div_code;
    wire [8:0] half_lim;
    wire       pre_tick;
    wire       half_done;

    assign pre_tick = i_run & (pre_cnt_ff == i_pre_sel);

    // reserved codes clamp to 512, never relied on
    assign div_code  = (i_div_sel > `SRG_DIV_MAX_CODE) ? `SRG_DIV_MAX_CODE : i_div_sel;
    assign half_lim  = (9'h001 << div_code) - 9'h001;
    assign half_done = pre_tick & (div_cnt_ff == half_lim);

    // next state; counters park at zero while stopped
    always @*
    begin
        nxt_pre_cnt = pre_cnt_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_sclk    = sclk_ff;
        if (!i_run)
        begin
            nxt_pre_cnt = 3'h0;
            nxt_div_cnt = 9'h000;
            nxt_sclk    = 1'b0;
        end
        else
        begin
            // prescaler steps on every bus clock
            nxt_pre_cnt = pre_tick ? 3'h0 : pre_cnt_ff + 3'h1;
            if (half_done)
            begin
                nxt_div_cnt = 9'h000;
                nxt_sclk    = ~sclk_ff;
            end
            else if (pre_tick)
            begin
                nxt_div_cnt = div_cnt_ff + 9'h001;
            end
        end
    end

    // state registers
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pre_cnt_ff <= 3'h0;
            div_cnt_ff <= 9'h000;
            sclk_ff    <= 1'b0;
        end
        else
        begin
            pre_cnt_ff <= nxt_pre_cnt;
            div_cnt_ff <= nxt_div_cnt;
            sclk_ff    <= nxt_sclk;
        end
    end

    // one sclk period is pre times div bus clocks
    assign o_pre_tick = pre_tick;
    assign o_edge     = half_done;
    assign o_sclk     = sclk_ff;

endmodule // srg_rate_gen

// ---- hw/srg_rx_flag.v ----
`timescale 1ns/100ps

// receive-full flag with its two clearing schemes
module srg_rx_flag
(
    // clock and reset
    input  wire i_clk,
    input  wire i_rst,
    // events
    input  wire i_set,
    input  wire i_sts_rd,
    input  wire i_dat_rd,
    input  wire i_dma_en,
    input  wire i_dma_done,
    // outputs
    output wire o_flag,
    output wire o_cleared
);

    reg  flag_ff;
    reg  armed_ff;
    reg  nxt_flag;
    reg  nxt_armed;
    wire clr;

    // dma done clears when dma enabled
    // else status read while set, then data read
    assign clr = i_dma_en ? i_dma_done : (armed_ff & i_dat_rd);

    // next state; a completing transfer beats a clear
    always @*
    begin
        nxt_flag = i_set ? 1'b1 : (clr ? 1'b0 : flag_ff);
        if (i_sts_rd & flag_ff & ~i_dma_en)
            nxt_armed = 1'b1;
        else if (clr | ~flag_ff | i_dma_en)
            nxt_armed = 1'b0;
        else
            nxt_armed = armed_ff;
    end

    // state registers
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            flag_ff  <= 1'b0;
            armed_ff <= 1'b0;
        end
        else
        begin
            flag_ff  <= nxt_flag;
            armed_ff <= nxt_armed;
        end
    end

    assign o_flag    = flag_ff;
    assign o_cleared = clr & flag_ff & ~i_set;

endmodule // srg_rx_flag

// ---- hw/srg_top.v ----
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "srg_regs.vh"

module srg_top
(
    // clock and reset
    input  wire        I_MCLK,
    input  wire        I_RST,
    // ahb-lite slave
    input  wire        I_HSEL,
    input  wire [31:0] I_HADDR,
    input  wire [1:0]  I_HTRANS,
    input  wire        I_HWRITE,
    input  wire [2:0]  I_HSIZE,
    input  wire [31:0] I_HWDATA,
    input  wire        I_HREADY,
    output wire [31:0] O_HRDATA,
    output wire        O_HREADYOUT,
    output wire        O_HRESP,
    // shifter side
    input  wire        I_XFER_DONE,
    input  wire [7:0]  I_RX_DATA,
    input  wire        I_RX_DMA_DONE,
    // serial clock
    output wire        O_SCLK,
    output wire        O_SCLK_EDGE,
    output wire        O_PRE_TICK,
    // receive status
    output wire        O_RX_FULL,
    output wire        O_RX_DMA_EN,
    // interrupt
    output wire        O_IRQ
);

    // bus pipeline registers
    reg  [7:0]  addr_ff;
    reg         wr_ff;
    reg  [31:0] rdata_ff;
    reg  [7:0]  nxt_addr;
    reg         nxt_wr;
    reg  [31:0] nxt_rdata;

    // software registers
    reg  [`SRG_CTRL_W-1:0] ctrl_ff;
    reg  [7:0]             rate_ff;
    reg  [7:0]             data_ff;
    reg  [`SRG_EV_W-1:0]   irq_sts_ff;
    reg  [`SRG_EV_W-1:0]   irq_en_ff;
    reg  [`SRG_CTRL_W-1:0] nxt_ctrl;
    reg  [7:0]             nxt_rate;
    reg  [7:0]             nxt_data;
    reg  [`SRG_EV_W-1:0]   nxt_irq_sts;
    reg  [`SRG_EV_W-1:0]   nxt_irq_en;

    // decoded bus activity
    wire                   addr_phase;
    wire                   rd_req;
    wire                   wr_data;
    wire [7:0]             req_addr;
    wire                   sts_rd;
    wire                   dat_rd;
    wire [7:0]             status_val;
    wire                   rx_full;
    wire                   rx_cleared;
    wire [`SRG_EV_W-1:0]   events;
    wire [`SRG_EV_W-1:0]   clr_bits;

    // a transfer is taken only when the bus is ready; size is ignored as
    // only whole words are issued, so narrow writes land on the low lanes
    assign addr_phase = I_HSEL & I_HREADY & (I_HTRANS == `SRG_HTRANS_NONSEQ);
    assign rd_req     = addr_phase & ~I_HWRITE;
    assign req_addr   = {I_HADDR[7:`SRG_WORD_SHIFT], 2'h0};
    assign wr_data    = wr_ff;

    // read side effects happen when the read is taken
    assign sts_rd = rd_req & (req_addr == `SRG_ADDR_STATUS);
    assign dat_rd = rd_req & (req_addr == `SRG_ADDR_DATA);

    // address phase capture; writes complete one cycle later
    always @*
    begin
        nxt_addr = addr_ff;
        nxt_wr   = 1'b0;
        if (addr_phase)
        begin
            nxt_addr = req_addr;
            nxt_wr   = I_HWRITE;
        end
    end

    always @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            addr_ff <= 8'h00;
            wr_ff   <= 1'b0;
        end
        else
        begin
            addr_ff <= nxt_addr;
            wr_ff   <= nxt_wr;
        end
    end

    // status image: only the receive-full bit lives here
    // low nibble tied to zero
    assign status_val = {rx_full, 3'h0, 4'h0};

    // read mux registered at the address phase so data stands in data phase
    always @*
    begin
        nxt_rdata = 32'h0000_0000;
        if (rd_req)
        begin
            case (req_addr)
                `SRG_ADDR_CTRL:    nxt_rdata = {30'h0000_0000, ctrl_ff};
                `SRG_ADDR_RATE:    nxt_rdata = {24'h00_0000, rate_ff};
                `SRG_ADDR_STATUS:  nxt_rdata = {24'h00_0000, status_val};
                `SRG_ADDR_DATA:    nxt_rdata = {24'h00_0000, data_ff};
                `SRG_ADDR_IRQ_STS: nxt_rdata = {30'h0000_0000, irq_sts_ff};
                `SRG_ADDR_IRQ_EN:  nxt_rdata = {30'h0000_0000, irq_en_ff};
                default:           nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge I_MCLK)
    begin
        if (I_RST)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= nxt_rdata;
    end

    // writable registers; the status and data addresses fall to default
    always @*
    begin
        nxt_ctrl   = ctrl_ff;
        nxt_rate   = rate_ff;
        nxt_irq_en = irq_en_ff;
        if (wr_data)
        begin
            case (addr_ff)
                `SRG_ADDR_CTRL:
                begin
                    nxt_ctrl = I_HWDATA[`SRG_CTRL_W-1:0];
                end
                `SRG_ADDR_RATE:
                begin
                    // reserved top bit stays zero
                    nxt_rate = I_HWDATA[7:0] & `SRG_RATE_WMASK;
                end
                `SRG_ADDR_IRQ_EN:
                begin
                    nxt_irq_en = I_HWDATA[`SRG_EV_W-1:0];
                end
                default:
                begin
                    nxt_ctrl   = ctrl_ff;
                    nxt_rate   = rate_ff;
                    nxt_irq_en = irq_en_ff;
                end
            endcase
        end
    end

    always @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            ctrl_ff   <= `SRG_CTRL_RST;
            rate_ff   <= `SRG_RATE_RST;
            irq_en_ff <= `SRG_EV_RST;
        end
        else
        begin
            ctrl_ff   <= nxt_ctrl;
            rate_ff   <= nxt_rate;
            irq_en_ff <= nxt_irq_en;
        end
    end

    // received byte held for software; a new transfer overwrites it
    always @*
    begin
        nxt_data = data_ff;
        if (I_XFER_DONE)
            nxt_data = I_RX_DATA;
    end

    always @(posedge I_MCLK)
    begin
        if (I_RST)
            data_ff <= 8'h00;
        else
            data_ff <= nxt_data;
    end

    // receive-full flag and its clearing sequence
    srg_rx_flag u_rx_flag
    (
        .i_clk      (I_MCLK),
        .i_rst      (I_RST),
        .i_set      (I_XFER_DONE),
        .i_sts_rd   (sts_rd),
        .i_dat_rd   (dat_rd),
        .i_dma_en   (ctrl_ff[`SRG_CTRL_RXDMA]),
        .i_dma_done (I_RX_DMA_DONE),
        .o_flag     (rx_full),
        .o_cleared  (rx_cleared)
    );

    // serial clock from both stages in series
    srg_rate_gen u_rate_gen
    (
        .i_clk      (I_MCLK),
        .i_rst      (I_RST),
        .i_run      (ctrl_ff[`SRG_CTRL_RUN]),
        .i_pre_sel  (rate_ff[`SRG_PRE_HI:`SRG_PRE_LO]),
        .i_div_sel  (rate_ff[`SRG_DIV_HI:`SRG_DIV_LO]),
        .o_pre_tick (O_PRE_TICK),
        .o_edge     (O_SCLK_EDGE),
        .o_sclk     (O_SCLK)
    );

    // interrupt events: transfer complete and receive-full cleared
    assign events[`SRG_EV_XFER]  = I_XFER_DONE;
    assign events[`SRG_EV_RXCLR] = rx_cleared;

    // write-one-to-clear bits, taken in the data phase
    assign clr_bits = (wr_data && addr_ff == `SRG_ADDR_IRQ_CLR) ?
                      I_HWDATA[`SRG_EV_W-1:0] : `SRG_EV_RST;

    // sticky status; an event in the clearing cycle survives
    always @*
    begin
        nxt_irq_sts = (irq_sts_ff & ~clr_bits) | events;
    end

    always @(posedge I_MCLK)
    begin
        if (I_RST)
            irq_sts_ff <= `SRG_EV_RST;
        else
            irq_sts_ff <= nxt_irq_sts;
    end

    // outputs; zero wait states, every answer is okay
    assign O_HRDATA    = rdata_ff;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = `SRG_HRESP_OKAY;
    assign O_RX_FULL   = rx_full;
    assign O_RX_DMA_EN = ctrl_ff[`SRG_CTRL_RXDMA];
    assign O_IRQ       = |(irq_sts_ff & irq_en_ff);

endmodule // srg_top

// ---- tb/srg_top_chk_sva.sv ----
`timescale 1ns/100ps
// port-level checks of the rate generator and the receive flag
module srg_top_chk
(
    // bus side
    input wire        I_MCLK,
    input wire        I_RST,
    input wire        I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0]  I_HTRANS,
    input wire        I_HWRITE,
    input wire        I_HREADY,
    input wire [31:0] O_HRDATA,
    // flag and serial clock
    input wire        I_XFER_DONE,
    input wire        I_RX_DMA_DONE,
    input wire        O_SCLK,
    input wire        O_SCLK_EDGE,
    input wire        O_PRE_TICK,
    input wire        O_RX_FULL,
    input wire        O_RX_DMA_EN
);
    // read address phase taken at this edge, and its word index
    wire       rd_ap = I_HSEL && I_HREADY && I_HTRANS == 2'h2 && !I_HWRITE;
    wire [5:0] idx   = I_HADDR[7:2];

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    AST_RD_IDLE: assert property (!$past(rd_ap) |-> O_HRDATA == 32'h0)
        else $error("read data outside data phase");
    AST_STS_ZERO: assert property ($past(rd_ap && idx == 6'h03) |-> O_HRDATA[3:0] == 4'h0)
        else $error("status low bits not zero");
    AST_FLAG_SET: assert property (I_XFER_DONE |=> O_RX_FULL)
        else $error("flag not set by transfer");
    AST_FLAG_CAUSE: assert property ($rose(O_RX_FULL) |-> $past(I_XFER_DONE))
        else $error("flag set without transfer");
    AST_FLAG_HOLD: assert property (O_RX_FULL && !O_RX_DMA_EN && !(rd_ap && idx == 6'h05) |=> O_RX_FULL)
        else $error("flag cleared without data read");
    AST_DMA_CLEAR: assert property (O_RX_DMA_EN && I_RX_DMA_DONE && !I_XFER_DONE |=> !O_RX_FULL)
        else $error("dma done did not clear flag");
    AST_SCLK_TOGGLE: assert property (O_SCLK_EDGE |=> O_SCLK != $past(O_SCLK))
        else $error("serial clock missed its edge");
    AST_EDGE_TICK: assert property (O_SCLK_EDGE |-> O_PRE_TICK)
        else $error("divider stepped off prescaler tick");

    COV_SET: cover property (I_XFER_DONE);
    COV_READ_CLEAR: cover property (!O_RX_DMA_EN && $fell(O_RX_FULL));
    COV_DMA_CLEAR: cover property (O_RX_DMA_EN && $fell(O_RX_FULL));
endmodule // srg_top_chk

bind srg_top srg_top_chk srg_top_chk_inst (.I_MCLK, .I_RST, .I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE, .I_HREADY,
    .O_HRDATA, .I_XFER_DONE, .I_RX_DMA_DONE, .O_SCLK, .O_SCLK_EDGE, .O_PRE_TICK, .O_RX_FULL, .O_RX_DMA_EN);

// ---- tb/srg_peer.sv ----
`timescale 1ns/100ps
// far-side peripheral: a byte completes after sixteen serial clock edges
module srg_peer
(
    // clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // commands and serial clock edges
    input  wire       i_edge,
    input  wire       i_start,
    input  wire [7:0] i_byte,
    input  wire       i_dma_req,
    // strobes toward the block
    output reg        o_done = 1'h0,
    output reg  [7:0] o_data = 8'h5A,
    output reg        o_dma_done = 1'h0
);
    reg       busy_ff;
    reg [3:0] cnt_ff;

    // data flips when not presented, so a stale byte never looks valid
    always @(posedge i_clk)
    begin
        o_done     <= 1'h0;
        o_dma_done <= i_dma_req & ~i_rst;
        o_data     <= ~o_data;
        if (i_rst)
            busy_ff <= 1'h0;
        else if (i_start)
        begin
            busy_ff <= 1'h1;
            cnt_ff  <= 4'h0;
        end
        else if (busy_ff && i_edge)
        begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == 4'hF)
            begin
                busy_ff <= 1'h0;
                o_done  <= 1'h1;
                o_data  <= i_byte;
            end
        end
    end
endmodule // srg_peer

// ---- tb/spi_rate_gen_and_rx_status_test.sv ----
`timescale 1ns/100ps
`include "srg_regs.vh"
module spi_rate_gen_and_rx_status_test;
    reg         clk = 1'h0;
    reg         rst = 1'h1;
    reg         hsel = 1'h0;
    reg  [7:0]  addr = 8'h00;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'h0;
    reg  [31:0] hwdata = 32'h0;
    reg         start = 1'h0;
    reg  [7:0]  tx = 8'h00;
    reg         dma_req = 1'h0;
    reg  [31:0] seed = 32'h92DB0DCC;
    reg  [31:0] rd;
    wire [31:0] hrdata;
    wire [7:0]  rx_data;
    wire        hready, xfer_done, dma_done, sclk_edge, rx_full, dma_en, irq;
    wire        hresp;
    integer     err_count = 0;
    integer     total_checks = 0;
    integer     i, p, d, n;

    // 250 MHz bus clock
    always #2 clk = ~clk;

    srg_top srg_top_inst
    (
        .I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR({24'h0, addr}), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_XFER_DONE(xfer_done), .I_RX_DATA(rx_data),
        .I_RX_DMA_DONE(dma_done), .O_SCLK(), .O_SCLK_EDGE(sclk_edge), .O_PRE_TICK(),
        .O_RX_FULL(rx_full), .O_RX_DMA_EN(dma_en), .O_IRQ(irq)
    );

    srg_peer srg_peer_inst
    (
        .i_clk(clk), .i_rst(rst), .i_edge(sclk_edge), .i_start(start), .i_byte(tx),
        .i_dma_req(dma_req), .o_done(xfer_done), .o_data(rx_data), .o_dma_done(dma_done)
    );

    // xorshift source, fixed seed keeps runs repeatable
    function [31:0] rnd();
    begin
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    end
    endfunction

    // serial clock period in bus cycles
    function integer period(input integer pre, input integer div);
        period = (pre + 1) * (2 << div);
    endfunction

    task stop_test;
    begin
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask

    task timeout;
    begin
        err_count = err_count + 1;
        $display("mismatch at %0t: wait ran out", $time);
        stop_test;
    end
    endtask

    // hready looked at before the edge so read data is taken free of races
    task wait_rdy(inout integer g);
    begin
        @(negedge clk);
        while (hready !== 1'h1 && g < 50)
        begin
            @(negedge clk);
            g = g + 1;
        end
        rd = hrdata;
        @(posedge clk);
    end
    endtask

    // one single word transfer: address phase, then data phase
    task bus(input w, input [7:0] a, input [31:0] wd);
        integer g;
    begin
        g = 0;
        @(posedge clk);
        hsel   <= 1'h1;
        htrans <= `SRG_HTRANS_NONSEQ;
        addr   <= a;
        hwrite <= w;
        wait_rdy(g);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(g);
        #1;
        // every access, a status write too, is answered okay
        chk(hresp, 1'h0);
        if (g >= 50)
            timeout;
    end
    endtask

    task xfer(input [7:0] b);
        integer g;
    begin
        g = 0;
        @(posedge clk);
        start <= 1'h1;
        tx    <= b;
        @(posedge clk);
        start <= 1'h0;
        while (rx_full !== 1'h1 && g < 1000)
        begin
            @(negedge clk);
            g = g + 1;
        end
        if (g >= 1000)
            timeout;
    end
    endtask

    // done strobe lands one cycle after the request, flag one after that
    task dma_pulse;
    begin
        @(posedge clk);
        dma_req <= 1'h1;
        @(posedge clk);
        dma_req <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
    end
    endtask

    // first three edges skipped: the counters may still run at the old rate
    task meas(output integer c);
        integer e, g;
    begin
        e = 0;
        c = 0;
        g = 0;
        while (e < 5 && g < 20000)
        begin
            @(negedge clk);
            g = g + 1;
            if (e >= 3)
                c = c + 1;
            if (sclk_edge === 1'h1)
                e = e + 1;
        end
        if (e < 5)
            timeout;
    end
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        // the first 17 words, unmapped ones too, read zero after reset
        for (i = 0; i < 17; i = i + 1)
        begin
            bus(1'h0, {i[5:0], 2'h0}, 32'h0);
            chk(rd, 32'h0);
        end
        // every prescale code, then divider codes 0 to 8 with a random prescale
        bus(1'h1, `SRG_ADDR_CTRL, 32'h1);
        for (i = 0; i < 17; i = i + 1)
        begin
            p = (i < 8) ? i : rnd() % 8;
            d = (i < 8) ? 0 : i - 8;
            bus(1'h1, `SRG_ADDR_RATE, {24'h0, 1'h1, p[2:0], d[3:0]});
            bus(1'h0, `SRG_ADDR_RATE, 32'h0);
            chk(rd, {25'h0, p[2:0], d[3:0]});
            meas(n);
            chk(n, period(p, d));
        end
        // fastest rate, transfer-done interrupt enabled
        bus(1'h1, `SRG_ADDR_RATE, 32'h0);
        bus(1'h1, `SRG_ADDR_IRQ_EN, 32'h1);
        n = rnd();
        xfer(n[7:0]);
        chk(irq, 1'h1);
        dma_pulse;
        chk(rx_full, 1'h1);
        bus(1'h0, `SRG_ADDR_DATA, 32'h0);
        chk(rd, {24'h0, tx});
        chk(rx_full, 1'h1);
        bus(1'h1, `SRG_ADDR_STATUS, 32'h0);
        bus(1'h0, `SRG_ADDR_STATUS, 32'h0);
        chk(rd, 32'h80);
        bus(1'h0, `SRG_ADDR_DATA, 32'h0);
        chk(rx_full, 1'h0);
        // both events latched; mask, then clear
        bus(1'h0, `SRG_ADDR_IRQ_STS, 32'h0);
        chk(rd, 32'h3);
        bus(1'h1, `SRG_ADDR_IRQ_EN, 32'h0);
        chk(irq, 1'h0);
        bus(1'h1, `SRG_ADDR_IRQ_CLR, 32'h3);
        bus(1'h0, `SRG_ADDR_IRQ_STS, 32'h0);
        chk(rd, 32'h0);
        // with dma the read sequence is ignored and dma done clears
        bus(1'h1, `SRG_ADDR_CTRL, 32'h3);
        chk(dma_en, 1'h1);
        n = rnd();
        xfer(n[7:0]);
        bus(1'h0, `SRG_ADDR_STATUS, 32'h0);
        bus(1'h0, `SRG_ADDR_DATA, 32'h0);
        chk(rx_full, 1'h1);
        dma_pulse;
        chk(rx_full, 1'h0);
        stop_test;
    end
endmodule // spi_rate_gen_and_rx_status_test
